//--- verilog/edmsg_top.sv
/*
 Data-memory select decode, bus mode, merged space and write guard.
 Assumes a core that waits while busy is high and a program-select
 decoder that supplies the hit vector and offset of each data address.
*/
module edmsg_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic por_flag,
    input wire logic bus_demux_strap,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire edmsg_pkg::edmsg_req_type req,
    output logic busy,
    output edmsg_pkg::edmsg_rsp_type rsp,
    input wire logic [7:0] port0_in,
    output edmsg_pkg::edmsg_pins_type pins,
    output logic guard_irq
);
    ////////////////////////////////////////////////////////////////////
    logic [2:0] p5_r, p5_nxt;
    logic [7:0] p6_r, p6_nxt, mlo_r, mlo_nxt, mhi_r, mhi_nxt;
    logic [7:0] guard_r, guard_nxt, rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic [2:0] strap_r, strap_nxt;
    logic [1:0] settle_r, settle_nxt;
    logic cap_r, cap_nxt, demux_r, demux_nxt;
    logic [7:0] d1_r, d2_r, d3_r, din_r, din_nxt;
    edmsg_pkg::edmsg_state_type state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    edmsg_pkg::edmsg_acc_type acc_r, acc_nxt;
    edmsg_pkg::edmsg_pins_type pins_r, pins_nxt;
    edmsg_pkg::edmsg_rsp_type rsp_r, rsp_nxt;
    logic busy_r, busy_nxt;
    logic fire, merged_hit, psel_hit, guard_hit;
    logic [2:0] sel_count, range;
    logic [4:0] shift;
    logic [21:0] idx_full;
    logic [7:0] merged_en, prog_sel;
    logic [3:0] guard_en, psel_dec, pin_en;

    assign reg_rdata = rdata_r;
    assign busy = busy_r;
    assign rsp = rsp_r;
    assign pins = pins_r;
    assign guard_irq = irq_r;

    ////////////////////////////////////////////////////////////////////
    // Decode of the pending request.
    always_comb begin
        case (p5_r)
            3'h4: sel_count = 3'h1;
            3'h5: sel_count = 3'h2;
            3'h6: sel_count = 3'h3;
            3'h7: sel_count = 3'h4;
            default: sel_count = 3'h0;
        endcase
        case (sel_count)
            3'h1: pin_en = 4'h1;
            3'h2: pin_en = 4'h3;
            3'h3: pin_en = 4'h7;
            3'h4: pin_en = 4'hf;
            default: pin_en = 4'h0;
        endcase
        case (p6_r[edmsg_pkg::P6_SIZE_LSB +: 3])
            3'h0: shift = 5'd15;
            3'h1: shift = 5'd17;
            3'h2: shift = 5'd18;
            3'h3: shift = 5'd19;
            default: shift = 5'd20;
        endcase
    end

    assign idx_full = req.addr >> shift;
    assign psel_hit = idx_full < {19'h0, sel_count};
    assign psel_dec = 4'h1 << idx_full[1:0];
    assign merged_en = {mhi_r[3:0], mlo_r[3:0]};
    assign merged_hit = |(merged_en & req.prog_hit);
    assign prog_sel = merged_hit ? (merged_en & req.prog_hit) : 8'h00;
    assign guard_en = guard_r[edmsg_pkg::GUARD_EN_LSB +: 4];
    assign range = guard_r[edmsg_pkg::GUARD_RANGE_LSB +: 3];
    assign guard_hit = req.write && |(guard_en & prog_sel[3:0])
        && req.prog_offset[21:14] == 8'h00 && req.prog_offset[13:11] <= range;
    assign fire = req.valid && state_r == edmsg_pkg::ST_IDLE && cap_r;

    ////////////////////////////////////////////////////////////////////
    // Register file and guard flag.
    always_comb begin
        p5_nxt = p5_r;
        p6_nxt = p6_r;
        mlo_nxt = mlo_r;
        mhi_nxt = mhi_r;
        guard_nxt = guard_r;
        rdata_nxt = 8'h00;
        if (reg_wr) begin
            if (reg_addr == edmsg_pkg::P5CFG_ADDR) begin
                p5_nxt = reg_wdata[edmsg_pkg::P5_SEL_LSB +: 3];
            end else if (reg_addr == edmsg_pkg::P6CFG_ADDR) begin
                p6_nxt = reg_wdata;
            end else if (reg_addr == edmsg_pkg::MEMLO_ADDR) begin
                mlo_nxt = reg_wdata;
            end else if (reg_addr == edmsg_pkg::MEMHI_ADDR) begin
                mhi_nxt = reg_wdata;
            end else if (reg_addr == edmsg_pkg::GUARD_ADDR) begin
                // Software can only clear the flag, never set it.
                guard_nxt = {guard_r[7] & reg_wdata[7], reg_wdata[6:0]};
            end
        end
        if (reg_rd) begin
            if (reg_addr == edmsg_pkg::P5CFG_ADDR) begin
                rdata_nxt = {5'h00, p5_r};
            end else if (reg_addr == edmsg_pkg::P6CFG_ADDR) begin
                rdata_nxt = p6_r;
            end else if (reg_addr == edmsg_pkg::MEMLO_ADDR) begin
                rdata_nxt = mlo_r;
            end else if (reg_addr == edmsg_pkg::MEMHI_ADDR) begin
                rdata_nxt = mhi_r;
            end else if (reg_addr == edmsg_pkg::GUARD_ADDR) begin
                rdata_nxt = guard_r;
            end
        end
        if (fire && guard_hit) begin
            guard_nxt[edmsg_pkg::GUARD_FLAG_BIT] = 1'b1;
        end
        irq_nxt = guard_nxt[edmsg_pkg::GUARD_FLAG_BIT] & mhi_nxt[edmsg_pkg::IRQ_EN_BIT];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            p5_r <= 3'h0;
            p6_r <= edmsg_pkg::REG_RESET;
            mlo_r <= edmsg_pkg::REG_RESET;
            mhi_r <= edmsg_pkg::REG_RESET;
            guard_r <= edmsg_pkg::REG_RESET;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            p5_r <= p5_nxt;
            p6_r <= p6_nxt;
            mlo_r <= mlo_nxt;
            mhi_r <= mhi_nxt;
            guard_r <= guard_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Strap capture and data-pin synchroniser.
    always_comb begin
        strap_nxt = {strap_r[1:0], bus_demux_strap};
        settle_nxt = settle_r;
        cap_nxt = cap_r;
        demux_nxt = demux_r;
        din_nxt = (d2_r == d3_r) ? d3_r : din_r;
        if (!cap_r) begin
            if (settle_r != edmsg_pkg::STRAP_SETTLE) begin
                settle_nxt = settle_r + 2'h1;
            end else if (strap_r[1] == strap_r[2]) begin
                cap_nxt = 1'b1;
                demux_nxt = por_flag & strap_r[2];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_r <= 3'h0;
            settle_r <= 2'h0;
            cap_r <= 1'b0;
            demux_r <= 1'b0;
            d1_r <= 8'h00;
            d2_r <= 8'h00;
            d3_r <= 8'h00;
            din_r <= 8'h00;
        end else begin
            strap_r <= strap_nxt;
            settle_r <= settle_nxt;
            cap_r <= cap_nxt;
            demux_r <= demux_nxt;
            d1_r <= port0_in;
            d2_r <= d1_r;
            d3_r <= d2_r;
            din_r <= din_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Access sequencer and pin drive.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        acc_nxt = acc_r;
        rsp_nxt = '0;
        case (state_r)
            edmsg_pkg::ST_IDLE: begin
                if (fire) begin
                    acc_nxt.write = req.write;
                    acc_nxt.addr = req.addr;
                    acc_nxt.wdata = req.wdata;
                    acc_nxt.psel = (!merged_hit && psel_hit && !guard_hit) ? psel_dec : 4'h0;
                    acc_nxt.prog = guard_hit ? 8'h00 : prog_sel;
                    acc_nxt.merged = merged_hit;
                    acc_nxt.blocked = guard_hit;
                    state_nxt = edmsg_pkg::ST_ADDR;
                    cnt_nxt = 3'h0;
                end
            end
            edmsg_pkg::ST_ADDR: begin
                if (cnt_r == edmsg_pkg::ADDR_CYC - 3'h1) begin
                    state_nxt = edmsg_pkg::ST_DATA;
                    cnt_nxt = 3'h0;
                end else begin
                    cnt_nxt = cnt_r + 3'h1;
                end
            end
            edmsg_pkg::ST_DATA: begin
                if (cnt_r == edmsg_pkg::DATA_CYC - 3'h1) begin
                    state_nxt = edmsg_pkg::ST_IDLE;
                    rsp_nxt.valid = 1'b1;
                    // The settled byte comes from the agree test itself; its register lags a cycle.
                    rsp_nxt.data = acc_r.write ? 8'h00 : din_nxt;
                end else begin
                    cnt_nxt = cnt_r + 3'h1;
                end
            end
            default: state_nxt = edmsg_pkg::ST_IDLE;
        endcase
        busy_nxt = state_nxt != edmsg_pkg::ST_IDLE || !cap_nxt;
    end

    always_comb begin
        pins_nxt = '0;
        pins_nxt.port7_oe_n = 1'b1;
        pins_nxt.port0_oe_n = 1'b1;
        pins_nxt.wr_n = 1'b1;
        pins_nxt.rd_n = 1'b1;
        pins_nxt.program_read_strobe_n = 1'b1;
        pins_nxt.psel_n = 4'hf;
        pins_nxt.prog_sel_n = 8'hff;
        pins_nxt.psel_pin_en = pin_en;
        if (state_nxt != edmsg_pkg::ST_IDLE) begin
            pins_nxt.addr_hi = acc_nxt.addr[21:16];
            pins_nxt.port2 = acc_nxt.addr[15:8];
            pins_nxt.psel_n = ~acc_nxt.psel;
            pins_nxt.prog_sel_n = ~acc_nxt.prog;
            if (demux_r) begin
                pins_nxt.port7 = acc_nxt.addr[7:0];
                pins_nxt.port7_oe_n = 1'b0;
            end
        end
        if (state_nxt == edmsg_pkg::ST_ADDR && !demux_r) begin
            pins_nxt.port0_out = acc_nxt.addr[7:0];
            pins_nxt.port0_oe_n = 1'b0;
            pins_nxt.ale = 1'b1;
        end
        if (state_nxt == edmsg_pkg::ST_DATA) begin
            if (acc_nxt.write) begin
                pins_nxt.port0_out = acc_nxt.wdata;
                pins_nxt.port0_oe_n = 1'b0;
                pins_nxt.wr_n = acc_nxt.blocked;
            end else if (acc_nxt.merged) begin
                pins_nxt.program_read_strobe_n = 1'b0;
            end else begin
                pins_nxt.rd_n = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= edmsg_pkg::ST_IDLE;
            cnt_r <= 3'h0;
            acc_r <= '0;
            rsp_r <= '0;
            busy_r <= 1'b1;
            pins_r <= '{addr_hi: 6'h00, port2: 8'h00, port7: 8'h00, port7_oe_n: 1'b1,
                port0_out: 8'h00, port0_oe_n: 1'b1, ale: 1'b0, wr_n: 1'b1, rd_n: 1'b1,
                program_read_strobe_n: 1'b1, psel_n: 4'hf, psel_pin_en: 4'h0, prog_sel_n: 8'hff};
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            acc_r <= acc_nxt;
            rsp_r <= rsp_nxt;
            busy_r <= busy_nxt;
            pins_r <= pins_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_psel_pins: assert property (@(posedge clk) disable iff (!reset_n)
        (p5_r == 3'h0 && $stable(p5_r)) |=> pins_r.psel_pin_en == 4'h0)
        else $error("select pins enabled with code zero");
    a_size_decode: assert property (@(posedge clk) disable iff (!reset_n)
        (fire && !merged_hit && !guard_hit && p6_r[5:3] == 3'h0 && p5_r == 3'h7
        && req.addr[21:17] == 5'h00) |=> acc_r.psel == (4'h1 << acc_r.addr[16:15]))
        else $error("32kB select decode wrong");
    a_mux_port7: assert property (@(posedge clk) disable iff (!reset_n)
        !demux_r |-> pins_r.port7_oe_n)
        else $error("port 7 driven in multiplexed mode");
    a_demux_noale: assert property (@(posedge clk) disable iff (!reset_n)
        demux_r |=> !pins_r.ale)
        else $error("latch strobe in demultiplexed mode");
    a_high_addr: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == edmsg_pkg::ST_DATA |-> pins_r.addr_hi == acc_r.addr[21:16])
        else $error("high address pins wrong");
    a_select_excl: assert property (@(posedge clk) disable iff (!reset_n)
        (&pins_r.psel_n) || (&pins_r.prog_sel_n))
        else $error("peripheral and program select together");
    a_merged_strobe: assert property (@(posedge clk) disable iff (!reset_n)
        !pins_r.program_read_strobe_n |-> pins_r.rd_n && pins_r.wr_n && acc_r.merged)
        else $error("program strobe on unmerged access");
    a_guard_range: assert property (@(posedge clk) disable iff (!reset_n)
        (fire && guard_hit) |-> req.prog_offset < ((22'(range) + 22'h1) << 11))
        else $error("guard hit outside range");
    a_guard_nowrite: assert property (@(posedge clk) disable iff (!reset_n)
        (fire && guard_hit) |=> guard_r[7] ##0 pins_r.wr_n [*5])
        else $error("guarded write not suppressed");
    a_sel_beyond: assert property (@(posedge clk) disable iff (!reset_n)
        (pins_r.psel_n | pins_r.psel_pin_en) == 4'hf)
        else $error("select beyond enabled count");
endmodule

//--- common/edmsg_pkg.sv
/*
 Constants and types of the external data-memory select and write guard.
 Assumes one 50 MHz clock and a core that issues one access at a time.
*/
package edmsg_pkg;
    localparam logic [7:0] P5CFG_ADDR = 8'ha2;
    localparam logic [7:0] P6CFG_ADDR = 8'hb2;
    localparam logic [7:0] MEMLO_ADDR = 8'hc6;
    localparam logic [7:0] MEMHI_ADDR = 8'hd6;
    localparam logic [7:0] GUARD_ADDR = 8'hd7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int P5_SEL_LSB = 0;
    localparam int P6_SIZE_LSB = 3;
    localparam int GUARD_EN_LSB = 0;
    localparam int GUARD_RANGE_LSB = 4;
    localparam int GUARD_FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 7;
    localparam logic [2:0] ADDR_CYC = 3'h1;
    localparam logic [2:0] DATA_CYC = 3'h4;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b11
    } edmsg_state_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [21:0] addr;
        logic [7:0] wdata;
        logic [7:0] prog_hit;
        logic [21:0] prog_offset;
    } edmsg_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } edmsg_rsp_type;

    typedef struct packed {
        logic write;
        logic [21:0] addr;
        logic [7:0] wdata;
        logic [3:0] psel;
        logic [7:0] prog;
        logic merged;
        logic blocked;
    } edmsg_acc_type;

    typedef struct packed {
        logic [5:0] addr_hi;
        logic [7:0] port2;
        logic [7:0] port7;
        logic port7_oe_n;
        logic [7:0] port0_out;
        logic port0_oe_n;
        logic ale;
        logic wr_n;
        logic rd_n;
        logic program_read_strobe_n;
        logic [3:0] psel_n;
        logic [3:0] psel_pin_en;
        logic [7:0] prog_sel_n;
    } edmsg_pins_type;
endpackage

//--- test/edmsg_mem_model.sv
/*
 Behavioural external memory and peripheral chips on the port-0 bus.
 Assumes registered, active-low strobes and selects from the select block.
*/
module edmsg_mem_model (
    input wire logic clk,
    input wire edmsg_pkg::edmsg_pins_type pins,
    output logic [7:0] port0_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [7:0] low_addr_r = 8'h00;
    logic [7:0] last_r = 8'h00;
    logic [7:0] addr;
    logic drive;
    logic sel;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // external address latch
    always @(negedge clk) begin
        if (pins.ale === 1'b1) begin
            low_addr_r <= pins.port0_out;
        end
    end
    assign addr = (pins.port7_oe_n === 1'b0) ? pins.port7 : low_addr_r;
    assign sel = (pins.psel_n !== 4'hf) || (pins.prog_sel_n !== 8'hff);
    assign drive = sel && ((pins.rd_n === 1'b0) || (pins.program_read_strobe_n === 1'b0));
    // A released bus shows the inverse of its last value, never a kind constant.
    assign port0_in = drive ? mem[addr] : ~last_r;
    always @(posedge clk) begin
        last_r <= port0_in;
        if (sel && pins.wr_n === 1'b0 && pins.port0_oe_n === 1'b0) begin
            mem[addr] <= pins.port0_out;
        end
    end
endmodule

//--- test/edmsg_top_tb.sv
/*
 Self-checking bench of the data-memory select and write guard.
 Assumes the memory model on the port-0 side and a 50 MHz clock.
*/
module edmsg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] p5;
        logic [2:0] p6;
        logic [21:0] addr;
        logic [3:0] sel_n;
        logic [3:0] pin_en;
    } edmsg_row_type;
    typedef struct packed {
        logic en;
        logic [2:0] code;
        logic [21:0] off;
        logic blocked;
    } edmsg_grow_type;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic por_flag = 1'b1;
    logic bus_demux_strap = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    edmsg_pkg::edmsg_req_type req = '0;
    logic busy;
    edmsg_pkg::edmsg_rsp_type rsp;
    logic [7:0] port0_in;
    edmsg_pkg::edmsg_pins_type pins;
    edmsg_pkg::edmsg_pins_type first_pins;
    logic guard_irq;
    logic [3:0] sel_seen;
    logic [7:0] prog_seen;
    logic wr_seen, program_read_strobe_seen, ale_seen, rd_seen;
    int errors = 0;
    int checks_done = 0;
    edmsg_row_type rows [9] = '{
        '{3'h0, 3'h0, 22'h000010, 4'hf, 4'h0}, '{3'h4, 3'h0, 22'h000111, 4'he, 4'h1},
        '{3'h4, 3'h0, 22'h008012, 4'hf, 4'h1}, '{3'h5, 3'h1, 22'h020213, 4'hd, 4'h3},
        '{3'h6, 3'h2, 22'h080314, 4'hb, 4'h7}, '{3'h6, 3'h2, 22'h0c0415, 4'hf, 4'h7},
        '{3'h7, 3'h3, 22'h180516, 4'h7, 4'hf}, '{3'h7, 3'h4, 22'h300617, 4'h7, 4'hf},
        '{3'h7, 3'h0, 22'h018118, 4'h7, 4'hf}};
    edmsg_grow_type grows [5] = '{'{1'b0, 3'h0, 22'h000001, 1'b0},
        '{1'b1, 3'h1, 22'h000fff, 1'b1}, '{1'b1, 3'h1, 22'h001000, 1'b0},
        '{1'b1, 3'h7, 22'h003fff, 1'b1}, '{1'b1, 3'h7, 22'h004000, 1'b0}};

    always #10 clk = ~clk;

    edmsg_top i_edmsg_top (.clk(clk), .reset_n(reset_n), .por_flag(por_flag),
        .bus_demux_strap(bus_demux_strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .busy(busy),
        .rsp(rsp), .port0_in(port0_in), .pins(pins), .guard_irq(guard_irq));
    edmsg_mem_model i_edmsg_mem_model (.clk(clk), .pins(pins), .port0_in(port0_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_expect(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(22'(reg_rdata), 22'(exp));
    endtask
    // Records what the pins did over one access, low strobes as seen-low, ale as seen-high.
    task automatic access(input logic w, input logic [21:0] a, input logic [7:0] d,
                          input logic [7:0] hit, input logic [21:0] off);
        int n;
        n = 0;
        while (busy !== 1'b0) begin
            @(negedge clk);
            n++;
            if (n > 40) begin
                errors++;
                final_report();
            end
        end
        @(posedge clk);
        req <= '{1'b1, w, a, d, hit, off};
        @(posedge clk);
        req.valid <= 1'b0;
        @(negedge clk);
        first_pins = pins;
        sel_seen = 4'hf;
        prog_seen = 8'hff;
        wr_seen = 1'b1;
        program_read_strobe_seen = 1'b1;
        rd_seen = 1'b1;
        ale_seen = 1'b0;
        n = 0;
        while (rsp.valid !== 1'b1) begin
            sel_seen &= pins.psel_n;
            prog_seen &= pins.prog_sel_n;
            wr_seen &= pins.wr_n;
            program_read_strobe_seen &= pins.program_read_strobe_n;
            rd_seen &= pins.rd_n;
            ale_seen |= pins.ale;
            @(negedge clk);
            n++;
            if (n > 20) begin
                errors++;
                final_report();
            end
        end
    endtask
    task automatic do_reset(input logic por, input logic strap);
        @(posedge clk);
        reset_n <= 1'b0;
        por_flag <= por;
        bus_demux_strap <= strap;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        @(negedge clk);
        check(22'({busy, pins.ale, pins.wr_n, pins.psel_n}), 22'h05f); // idle in reset
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        reg_write(8'h10, 8'hff);
        foreach (rows[i]) begin
            reg_expect(i < 5 ? edmsg_pkg::P5CFG_ADDR + 8'(i * 16) : 8'h10, 8'h00); // reset
        end
        foreach (rows[i]) begin
            reg_write(edmsg_pkg::P5CFG_ADDR, {5'h00, rows[i].p5});
            reg_write(edmsg_pkg::P6CFG_ADDR, {2'h0, rows[i].p6, 3'h0});
            access(1'b0, rows[i].addr, 8'h00, 8'h00, 22'h000000);
            check(22'(sel_seen), 22'(rows[i].sel_n)); // select decode
            check(22'(pins.psel_pin_en), 22'(rows[i].pin_en)); // pin function
            check(22'(first_pins.addr_hi), 22'(rows[i].addr[21:16])); // upper address
            check(22'({first_pins.port2, first_pins.port0_out}), 22'(rows[i].addr[15:0]));
            check(22'(ale_seen), 22'h1); // multiplexed bus
            check(22'(rd_seen), 22'h0); // plain read strobe
            if (rows[i].sel_n != 4'hf) begin
                check(22'(rsp.data), 22'(rows[i].addr[7:0] ^ 8'h5a)); // data read
            end
        end
        reg_write(edmsg_pkg::MEMLO_ADDR, 8'h01);
        access(1'b1, 22'h000040, 8'hc3, 8'h01, 22'h000040);
        check(22'({sel_seen, prog_seen, wr_seen}), 22'h1ffc); // merged write
        access(1'b0, 22'h000040, 8'h00, 8'h01, 22'h000040);
        check(22'({sel_seen, prog_seen, program_read_strobe_seen, rd_seen}), 22'h3ff9);
        check(22'(rsp.data), 22'hc3); // merged read data
        foreach (grows[i]) begin
            reg_write(edmsg_pkg::GUARD_ADDR, {1'b0, grows[i].code, 3'h0, grows[i].en});
            access(1'b1, grows[i].off, 8'h3c, 8'h01, grows[i].off);
            check(22'({wr_seen, prog_seen[0]}), 22'({2{grows[i].blocked}}));
            reg_expect(edmsg_pkg::GUARD_ADDR,
                       {grows[i].blocked, grows[i].code, 3'h0, grows[i].en}); // flag
        end
        access(1'b0, 22'h004000, 8'h00, 8'h01, 22'h004000);
        check(22'(rsp.data), 22'h3c); // unguarded write landed
        access(1'b1, 22'h000010, 8'h77, 8'h01, 22'h000010);
        check(22'(guard_irq), 22'h0); // interrupt disabled
        reg_write(edmsg_pkg::MEMHI_ADDR, 8'h80);
        repeat (2) @(negedge clk);
        check(22'(guard_irq), 22'h1); // interrupt raised
        reg_write(edmsg_pkg::GUARD_ADDR, 8'h71);
        repeat (2) @(negedge clk);
        check(22'(guard_irq), 22'h0); // flag cleared
        do_reset(1'b1, 1'b1);
        @(negedge clk);
        check(22'({busy, pins.port7_oe_n}), 22'h3); // busy and multiplexed after reset
        reg_write(edmsg_pkg::P5CFG_ADDR, 8'h04);
        access(1'b0, 22'h000123, 8'h00, 8'h00, 22'h000000);
        check(22'({first_pins.port7, first_pins.port7_oe_n, ale_seen}), 22'h08c); // demux
        check(22'({sel_seen, rsp.data}), 22'he79); // demux read
        do_reset(1'b0, 1'b1);
        reg_write(edmsg_pkg::P5CFG_ADDR, 8'h04);
        access(1'b0, 22'h000123, 8'h00, 8'h00, 22'h000000);
        check(22'({ale_seen, rsp.data}), 22'h179); // later reset stays multiplexed
        final_report();
    end
endmodule
